/* common/port_pkg.sv */
package port_pkg;

	localparam int CHANNELS   = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int COUNT_W    = 16;
	localparam int ENTRY_W    = 36;

	// register byte addresses
	localparam logic [11:0] ADDR_CONTROL   = 12'h000;
	localparam logic [11:0] ADDR_CH_CTRL   = 12'h004;
	localparam logic [11:0] ADDR_FIFO_HEAD = 12'h008;
	localparam logic [11:0] ADDR_STATUS    = 12'h00c;
	localparam logic [4:0]  CH_SPACE_TAG   = 5'h01;

	// per-channel parameter word, paddr[3:2]
	localparam logic [1:0] PAR_INDEX_A = 2'h0;
	localparam logic [1:0] PAR_MODIFY  = 2'h1;
	localparam logic [1:0] PAR_COUNT   = 2'h2;
	localparam logic [1:0] PAR_INDEX_B = 2'h3;

	// port_global_control fields
	localparam int NSET_LSB   = 0;
	localparam int FFCLR_BIT  = 4;
	localparam int GDMA_BIT   = 5;
	localparam int CLROVF_BIT = 6;
	localparam int PEN_BIT    = 7;
	localparam int MODE_LSB   = 8;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// channel control fields
	localparam int CHEN_LSB = 0;
	localparam int PING_LSB = 8;

	// peripheral_status_register fields
	localparam int STAT_OVF_LSB = 0;
	localparam int STAT_THR_BIT = 8;
	localparam int STAT_DMA_LSB = 17;
	localparam int STAT_OCC_LSB = 28;

	// fifo word layout
	localparam int TAG_LSB     = 0;
	localparam int LR_BIT      = 3;
	localparam int PAYLOAD_LSB = 4;

	typedef enum logic [2:0] {
		MODE_I2S24  = 3'h0,
		MODE_LJ24   = 3'h1,
		MODE_RJ24   = 3'h2,
		MODE_RJ20   = 3'h3,
		MODE_RJ18   = 3'h4,
		MODE_RJ16   = 3'h5,
		MODE_I2S32  = 3'h6,
		MODE_LJ32   = 3'h7
	} framing_mode_t;

	typedef enum logic [0:0] {
		DMA_IDLE = 1'b0,
		DMA_WAIT = 1'b1
	} dma_state_t;

endpackage : port_pkg

/* design/fixed_priority_pick.sv */
`timescale 1ns/1ps
module fixed_priority_pick (
	input  wire logic [7:0] ready,
	output logic            any,
	output logic [2:0]      pick
);
	// channel 0 has the highest priority
	always_comb
	begin
		pick = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (ready[i])
				pick = 3'(i);
		end
	end

	assign any = |ready;

endmodule : fixed_priority_pick

/* design/input_port_dma.sv */
`timescale 1ns/1ps
module input_port_dma (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sample_valid,
	input  wire logic [2:0]  sample_channel,
	input  wire logic        sample_frame_sync,
	input  wire logic        sample_parallel,
	input  wire logic [31:0] sample_data,
	output logic             dma_req,
	output logic      [31:0] dma_addr,
	output logic      [31:0] dma_data,
	input  wire logic        dma_grant,
	output logic      [7:0]  dma_done,
	output logic             threshold_irq
);
	logic [31:0]                   port_global_control;
	logic [15:0]                   channel_control;
	logic [7:0]                    channel_overflow_flag;
	logic                          rd_had_data;
	port_pkg::dma_state_t          dma_state;
	logic [2:0]                    win;
	logic                          win_raw;
	logic [31:0]                   index_a   [port_pkg::CHANNELS];
	logic [31:0]                   index_b   [port_pkg::CHANNELS];
	logic [31:0]                   modify    [port_pkg::CHANNELS];
	logic [port_pkg::COUNT_W-1:0]  count_set [port_pkg::CHANNELS];
	logic [31:0]                   cur_index [port_pkg::CHANNELS];
	logic [port_pkg::COUNT_W-1:0]  cur_count [port_pkg::CHANNELS];
	logic [31:0]                   hold_data [port_pkg::CHANNELS];
	logic [7:0]                    hold_valid;
	logic [7:0]                    hold_raw;
	logic [7:0]                    side_b;

	// control fields
	wire       port_enable       = port_global_control[port_pkg::PEN_BIT];
	wire       global_dma_enable = port_global_control[port_pkg::GDMA_BIT];
	wire [3:0] nset              = port_global_control[port_pkg::NSET_LSB +: 4];
	wire [7:0] channel_dma_enable      = channel_control[port_pkg::CHEN_LSB +: 8];
	wire [7:0] channel_pingpong_select = channel_control[port_pkg::PING_LSB +: 8];
	wire       dma_mode = global_dma_enable && (|channel_dma_enable);

	// bus decode
	wire        setup_done = psel && penable && !pready;
	wire        acc        = psel && penable && pready;
	wire        wr_acc     = acc && pwrite;
	wire        hit_ctrl   = (paddr == port_pkg::ADDR_CONTROL);
	wire        hit_chctl  = (paddr == port_pkg::ADDR_CH_CTRL);
	wire        hit_head   = (paddr == port_pkg::ADDR_FIFO_HEAD);
	wire        hit_stat   = (paddr == port_pkg::ADDR_STATUS);
	wire        hit_chan   = (paddr[11:7] == port_pkg::CH_SPACE_TAG) && (paddr[1:0] == 2'h0);
	wire [2:0]  par_ch     = paddr[6:4];
	wire [1:0]  par_sel    = paddr[3:2];
	wire        mapped     = hit_ctrl || hit_chctl || hit_head || hit_stat || hit_chan;
	wire        ctrl_wr    = wr_acc && hit_ctrl;
	wire        fifo_clear_bit    = ctrl_wr && pwdata[port_pkg::FFCLR_BIT];
	wire        clear_overflow_bit = ctrl_wr && pwdata[port_pkg::CLROVF_BIT];

	// incoming sample formatting
	wire [4:0]                mode_pos  = {2'h0, sample_channel} + {1'b0, sample_channel, 1'b0};
	wire [23:0]               mode_bits = port_global_control[port_pkg::MODE_LSB +: 24];
	wire port_pkg::framing_mode_t channel_framing_mode =
		port_pkg::framing_mode_t'(mode_bits[mode_pos +: 3]);
	wire is_i2s = (channel_framing_mode == port_pkg::MODE_I2S24) ||
		(channel_framing_mode == port_pkg::MODE_I2S32);
	wire left_right_flag = is_i2s ? !sample_frame_sync : sample_frame_sync;
	wire in_raw = sample_parallel || (channel_framing_mode == port_pkg::MODE_I2S32) ||
		(channel_framing_mode == port_pkg::MODE_LJ32);
	wire [2:0]  source_channel_tag = sample_parallel ? 3'h0 : sample_channel;
	logic [27:0] keep_mask;
	always_comb
	begin
		case (channel_framing_mode)
			// 24-bit frames carry no data in bits 7-4, so those read as zero
			port_pkg::MODE_I2S24,
			port_pkg::MODE_LJ24,
			port_pkg::MODE_RJ24: keep_mask = 28'hffffff0;
			port_pkg::MODE_RJ20: keep_mask = 28'hfffff00;
			port_pkg::MODE_RJ18: keep_mask = 28'hffffc00;
			port_pkg::MODE_RJ16: keep_mask = 28'hffff000;
			default:             keep_mask = 28'hfffffff;
		endcase
	end
	wire [27:0] serial_payload = sample_data[31:port_pkg::PAYLOAD_LSB] & keep_mask;
	wire [31:0] in_word = in_raw ? sample_data :
		{serial_payload, left_right_flag, source_channel_tag};

	// fifo
	wire [port_pkg::ENTRY_W-1:0] fifo_head;
	wire [3:0]                   fifo_occupancy;
	wire                         fifo_full;
	wire                         fifo_empty;
	wire                         fifo_flush = !port_enable || fifo_clear_bit;
	wire                         fifo_push  = sample_valid && port_enable && !fifo_full;
	wire                         head_raw   = fifo_head[35];
	wire [2:0]                   head_tag   = fifo_head[34:32];
	wire [31:0]                  head_word  = fifo_head[31:0];

	// routing from fifo head to the channel holding registers
	logic [7:0] chan_run;
	logic [7:0] chan_drop;
	wire  head_drop = chan_drop[head_tag];
	wire  head_take = chan_run[head_tag] && !hold_valid[head_tag];
	wire  dma_pop   = dma_mode && !fifo_empty && (head_drop || head_take);
	wire  core_pop  = acc && !pwrite && hit_head && rd_had_data;
	wire [7:0] route_load = (dma_pop && head_take) ? (8'h01 << head_tag) : 8'h00;

	sample_fifo u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.flush     (fifo_flush),
		.push      (fifo_push),
		.push_data ({in_raw, source_channel_tag, in_word}),
		.pop       (dma_pop || core_pop),
		.head      (fifo_head),
		.count     (fifo_occupancy),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	// arbitration among channels holding a word
	wire       arb_any;
	wire [2:0] arb_pick;
	fixed_priority_pick u_pick (
		.ready (hold_valid & chan_run),
		.any   (arb_any),
		.pick  (arb_pick)
	);

	wire       grant_now = (dma_state == port_pkg::DMA_WAIT) && dma_grant;
	wire [7:0] upd       = grant_now ? (8'h01 << win) : 8'h00;

	// per channel parameters, live pointers and holding word
	for (genvar c = 0; c < port_pkg::CHANNELS; c++)
	begin : g_ch
		wire par_wr  = wr_acc && hit_chan && (par_ch == 3'(c));
		wire last    = (cur_count[c] == port_pkg::COUNT_W'(1));
		assign chan_run[c]  = port_enable && global_dma_enable && channel_dma_enable[c] &&
			(cur_count[c] != '0);
		assign chan_drop[c] = port_enable && global_dma_enable && channel_dma_enable[c] &&
			!channel_pingpong_select[c] && (cur_count[c] == '0);

		always_ff @(posedge clk_sys or negedge rstn)
		begin
			if (!rstn)
			begin
				index_a[c]   <= 32'h0;
				index_b[c]   <= 32'h0;
				modify[c]    <= 32'h0;
				count_set[c] <= '0;
				cur_index[c] <= 32'h0;
				cur_count[c] <= '0;
				side_b[c]    <= 1'b0;
			end
			else
			begin
				if (upd[c] && last && channel_pingpong_select[c])
				begin
					side_b[c]    <= !side_b[c];
					cur_index[c] <= side_b[c] ? index_a[c] : index_b[c];
					cur_count[c] <= count_set[c];
				end
				else if (upd[c])
				begin
					cur_index[c] <= cur_index[c] + modify[c];
					cur_count[c] <= cur_count[c] - port_pkg::COUNT_W'(1);
				end
				if (par_wr && par_sel == port_pkg::PAR_INDEX_A)
				begin
					index_a[c]   <= pwdata;
					cur_index[c] <= pwdata;
					side_b[c]    <= 1'b0;
				end
				if (par_wr && par_sel == port_pkg::PAR_INDEX_B)
					index_b[c] <= pwdata;
				if (par_wr && par_sel == port_pkg::PAR_MODIFY)
					modify[c] <= pwdata;
				if (par_wr && par_sel == port_pkg::PAR_COUNT)
				begin
					count_set[c] <= pwdata[port_pkg::COUNT_W-1:0];
					cur_count[c] <= pwdata[port_pkg::COUNT_W-1:0];
				end
			end
		end

		always_ff @(posedge clk_sys or negedge rstn)
		begin
			if (!rstn)
			begin
				hold_valid[c] <= 1'b0;
				hold_raw[c]   <= 1'b0;
				hold_data[c]  <= 32'h0;
				dma_done[c]   <= 1'b0;
			end
			else
			begin
				dma_done[c] <= upd[c] && last;
				if (!port_enable)
					hold_valid[c] <= 1'b0;
				else if (route_load[c])
				begin
					hold_valid[c] <= 1'b1;
					hold_raw[c]   <= head_raw;
					hold_data[c]  <= head_raw ? head_word : {head_word[31:3], 3'h0};
				end
				else if (upd[c])
					hold_valid[c] <= 1'b0;
			end
		end

		chk_index_step: assert property (@(posedge clk_sys) disable iff (!rstn)
			upd[c] && !last && !par_wr |=>
			cur_index[c] == $past(cur_index[c]) + $past(modify[c]) &&
			cur_count[c] == $past(cur_count[c]) - port_pkg::COUNT_W'(1))
			else $error("dma index or count did not step");
		chk_done_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
			upd[c] && last |=> dma_done[c] ##1 !dma_done[c])
			else $error("dma done pulse missing at count end");
	end

	// one word at a time goes to the peripheral bus arbiter
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			dma_state <= port_pkg::DMA_IDLE;
			dma_req   <= 1'b0;
			dma_addr  <= 32'h0;
			dma_data  <= 32'h0;
			win       <= 3'h0;
			win_raw   <= 1'b0;
		end
		else
		begin
			case (dma_state)
				port_pkg::DMA_IDLE:
				begin
					if (arb_any)
					begin
						dma_state <= port_pkg::DMA_WAIT;
						dma_req   <= 1'b1;
						win       <= arb_pick;
						win_raw   <= hold_raw[arb_pick];
						dma_addr  <= cur_index[arb_pick];
						dma_data  <= hold_data[arb_pick];
					end
				end
				port_pkg::DMA_WAIT:
				begin
					if (dma_grant)
					begin
						dma_state <= port_pkg::DMA_IDLE;
						dma_req   <= 1'b0;
					end
				end
				default:
				begin
					dma_state <= port_pkg::DMA_IDLE;
					dma_req   <= 1'b0;
				end
			endcase
		end
	end

	// overflow flags: a new overflow wins over a clear in the same cycle
	wire [7:0] ovf_set = (sample_valid && port_enable && fifo_full) ?
		(8'h01 << source_channel_tag) : 8'h00;
	wire       ovf_clr = clear_overflow_bit || !port_enable;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			channel_overflow_flag <= 8'h00;
		else
			channel_overflow_flag <= (channel_overflow_flag & ~{8{ovf_clr}}) | ovf_set;
	end

	// core interrupt is suppressed while dma owns the fifo
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			threshold_irq <= 1'b0;
		else
			threshold_irq <= !dma_mode && (fifo_occupancy > nset);
	end

	// control registers; clear bits act once and read back as zero
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			port_global_control <= port_pkg::CONTROL_RESET;
			channel_control     <= 16'h0000;
		end
		else
		begin
			if (ctrl_wr)
				port_global_control <= pwdata &
					~((32'h1 << port_pkg::FFCLR_BIT) | (32'h1 << port_pkg::CLROVF_BIT));
			if (wr_acc && hit_chctl)
				channel_control <= pwdata[15:0];
		end
	end

	// read mux
	wire [31:0] peripheral_status_register =
		({28'h0, fifo_occupancy} << port_pkg::STAT_OCC_LSB) |
		({24'h0, chan_run} << port_pkg::STAT_DMA_LSB) |
		({31'h0, threshold_irq} << port_pkg::STAT_THR_BIT) |
		({24'h0, channel_overflow_flag} << port_pkg::STAT_OVF_LSB);
	wire [31:0] fifo_head_register = fifo_empty ? 32'h0 : head_word;
	logic [31:0] chan_read;
	always_comb
	begin
		case (par_sel)
			port_pkg::PAR_INDEX_A: chan_read = cur_index[par_ch];
			port_pkg::PAR_MODIFY:  chan_read = modify[par_ch];
			port_pkg::PAR_COUNT:   chan_read = {16'h0, cur_count[par_ch]};
			default:               chan_read = index_b[par_ch];
		endcase
	end
	wire [31:0] read_value =
		hit_ctrl  ? port_global_control :
		hit_chctl ? {16'h0, channel_control} :
		hit_head  ? fifo_head_register :
		hit_stat  ? peripheral_status_register :
		hit_chan  ? chan_read : 32'h0;

	// one wait state: data captured at the end of the first access cycle
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			prdata      <= 32'h0;
			rd_had_data <= 1'b0;
		end
		else
		begin
			pready      <= setup_done;
			pslverr     <= setup_done && !mapped;
			rd_had_data <= setup_done && !pwrite && hit_head && !fifo_empty && !dma_mode;
			if (setup_done && !pwrite)
				prdata <= read_value;
		end
	end

	chk_tag_low_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
		fifo_push && !in_raw |-> in_word[2:0] == source_channel_tag)
		else $error("serial word lacks its channel tag");
	chk_lj_left_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
		fifo_push && channel_framing_mode == port_pkg::MODE_LJ24 && !sample_parallel
		|-> in_word[port_pkg::LR_BIT] == sample_frame_sync)
		else $error("left flag wrong in left-justified mode");
	chk_rj16_zeroed: assert property (@(posedge clk_sys) disable iff (!rstn)
		fifo_push && channel_framing_mode == port_pkg::MODE_RJ16 && !sample_parallel
		|-> in_word[15:4] == 12'h000)
		else $error("right-justified 16-bit padding not zero");
	chk_fifo_depth: assert property (@(posedge clk_sys) disable iff (!rstn)
		fifo_occupancy <= 4'h8)
		else $error("fifo occupancy above eight");
	chk_overflow_set: assert property (@(posedge clk_sys) disable iff (!rstn)
		sample_valid && port_enable && fifo_full |=>
		channel_overflow_flag[$past(source_channel_tag)] && $stable(fifo_occupancy) ||
		$past(core_pop || dma_pop || fifo_flush))
		else $error("overflow not flagged on full fifo");
	chk_disable_flush: assert property (@(posedge clk_sys) disable iff (!rstn)
		!port_enable |=> fifo_occupancy == 4'h0 && channel_overflow_flag == 8'h00)
		else $error("port disable did not flush");
	chk_dma_tag_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
		dma_req && !win_raw |-> dma_data[2:0] == 3'h0)
		else $error("dma word still carries channel tag");
	chk_req_held: assert property (@(posedge clk_sys) disable iff (!rstn)
		dma_req && !dma_grant |=> dma_req && $stable(dma_addr) && $stable(dma_data))
		else $error("dma request dropped before grant");
	chk_empty_read: assert property (@(posedge clk_sys) disable iff (!rstn)
		setup_done && !pwrite && hit_head && fifo_empty |=> prdata == 32'h0 && !rd_had_data)
		else $error("empty head read not zero");
	chk_threshold: assert property (@(posedge clk_sys) disable iff (!rstn)
		!dma_mode && fifo_occupancy > nset |=> threshold_irq)
		else $error("threshold interrupt missing");

endmodule : input_port_dma

/* design/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	input  wire logic                        flush,
	input  wire logic                        push,
	input  wire logic [port_pkg::ENTRY_W-1:0] push_data,
	input  wire logic                        pop,
	output logic      [port_pkg::ENTRY_W-1:0] head,
	output logic      [3:0]                  count,
	output logic                             full,
	output logic                             empty
);
	logic [port_pkg::ENTRY_W-1:0] mem [port_pkg::FIFO_DEPTH];
	logic [2:0]                   wr_ptr;
	logic [2:0]                   rd_ptr;
	wire                          do_push = push && !full;
	wire                          do_pop  = pop && !empty;

	assign head  = mem[rd_ptr];
	assign full  = (count == 4'h8);
	assign empty = (count == 4'h0);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr <= 3'h0;
			rd_ptr <= 3'h0;
			count  <= 4'h0;
		end
		else if (flush)
		begin
			wr_ptr <= 3'h0;
			rd_ptr <= 3'h0;
			count  <= 4'h0;
		end
		else
		begin
			wr_ptr <= wr_ptr + {2'h0, do_push};
			rd_ptr <= rd_ptr + {2'h0, do_pop};
			count  <= count + {3'h0, do_push} - {3'h0, do_pop};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

endmodule : sample_fifo

/* verif/input_port_dma_bench.sv */
`timescale 1ns/1ps
module input_port_dma_bench;
	// modes ch7..ch0: i2s24 x3, lj24, lj24, i2s24, rj16, lj32
	localparam logic [31:0] CTRL_PEN = {3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h5, 3'h7, 8'h80};
	localparam logic [31:0] HEADS [4] = '{32'hffff_0009, 32'h1234_560a, 32'habcd_ef02,
		32'h1234_5677};
	localparam logic [31:0] EXP_ADDR [5] = '{32'h100, 32'h104, 32'h200, 32'h300, 32'h200};
	localparam logic [31:0] EXP_DATA [5] = '{32'haabb_cc08, 32'h1122_3300, 32'h5566_7708,
		32'h5566_7708, 32'h5566_7708};
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sample_valid = 1'b0;
	logic [2:0]  sample_channel = 3'h0;
	logic        sample_frame_sync = 1'b0;
	logic        sample_parallel = 1'b0;
	logic [31:0] sample_data = 32'h0;
	logic        dma_req;
	logic [31:0] dma_addr;
	logic [31:0] dma_data;
	logic        dma_grant;
	logic [7:0]  dma_done;
	logic        threshold_irq;
	logic [3:0]  stall = 4'h0;
	logic [31:0] rdata;
	logic        rerr;
	logic [7:0]  done_seen = 8'h0;
	int          done4 = 0;
	int          fails = 0;
	int          n_compared = 0;

	input_port_dma i_dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
		.sample_channel(sample_channel), .sample_frame_sync(sample_frame_sync),
		.sample_parallel(sample_parallel), .sample_data(sample_data), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_data(dma_data), .dma_grant(dma_grant),
		.dma_done(dma_done), .threshold_irq(threshold_irq));
	memory_partner i_mem (.clk_sys(clk_sys), .rstn(rstn), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_data(dma_data), .stall(stall), .dma_grant(dma_grant));

	always #10 clk_sys = ~clk_sys;

	// done pulses last one cycle, so collect them here
	always @(posedge clk_sys)
	begin
		done_seen <= done_seen | dma_done;
		if (dma_done[4] === 1'b1)
			done4 <= done4 + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1 && ++n < 50);
		rdata = prdata;
		rerr  = pslverr;
		check({31'h0, pready}, 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic put(input logic [2:0] ch, input logic fs, input logic par, input logic [31:0] d);
		sample_valid      <= 1'b1;
		sample_channel    <= ch;
		sample_frame_sync <= fs;
		sample_parallel   <= par;
		sample_data       <= d;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		@(posedge clk_sys);
	endtask : put

	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	initial
	begin
		#200_000;
		fails++;
		final_report();
	end

	initial
	begin
		int n;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		check({rdata[30:0], rerr}, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		check(rdata, 32'h0);
		apb(1'b1, 12'h000, CTRL_PEN | 32'h1);
		put(3'h1, 1'b1, 1'b0, 32'hffff_ffff);
		apb(1'b0, 12'h00c, 32'h0);
		check({rdata[31:28], 27'h0, threshold_irq}, 32'h1000_0000);
		put(3'h2, 1'b0, 1'b0, 32'h1234_56ff);
		put(3'h2, 1'b1, 1'b0, 32'habcd_ef77);
		put(3'h0, 1'b0, 1'b1, 32'h1234_5677);
		apb(1'b0, 12'h00c, 32'h0);
		check({rdata[31:28], 27'h0, threshold_irq}, 32'h4000_0001);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 12'h008, 32'h0);
			check(rdata, HEADS[i]);
		end
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h0);
		repeat (9) put(3'h2, 1'b0, 1'b0, 32'h0000_0100);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h8000_0104);
		apb(1'b1, 12'h000, CTRL_PEN | 32'h41);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h8000_0100);
		apb(1'b1, 12'h000, CTRL_PEN | 32'h11);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h0);
		repeat (9) put(3'h2, 1'b0, 1'b0, 32'h0000_0100);
		apb(1'b1, 12'h000, 32'h0);
		put(3'h2, 1'b0, 1'b0, 32'h0000_0100);
		apb(1'b0, 12'h00c, 32'h0);
		check(rdata, 32'h0);
		// channel 3 standard through a slow memory, channel 4 ping-pong
		stall <= 4'h3;
		apb(1'b1, 12'h0b0, 32'h100);
		apb(1'b1, 12'h0b4, 32'h4);
		apb(1'b1, 12'h0b8, 32'h2);
		apb(1'b1, 12'h0c0, 32'h200);
		apb(1'b1, 12'h0c4, 32'h4);
		apb(1'b1, 12'h0c8, 32'h1);
		apb(1'b1, 12'h0cc, 32'h300);
		apb(1'b1, 12'h004, 32'h0000_1018);
		apb(1'b1, 12'h000, CTRL_PEN | 32'h21);
		put(3'h3, 1'b1, 1'b0, 32'haabb_ccdd);
		put(3'h3, 1'b0, 1'b0, 32'h1122_33ff);
		put(3'h3, 1'b1, 1'b0, 32'h7777_7777);
		repeat (3) put(3'h4, 1'b1, 1'b0, 32'h5566_77aa);
		n = 0;
		while (i_mem.addr_log.size() < 5 && n < 400)
		begin
			@(posedge clk_sys);
			n++;
		end
		repeat (20) @(posedge clk_sys);
		check(32'(i_mem.addr_log.size()), 32'h5);
		for (int i = 0; i < 5; i++)
		begin
			check(i_mem.addr_log[i], EXP_ADDR[i]);
			check(i_mem.data_log[i], EXP_DATA[i]);
		end
		check({24'h0, done_seen}, 32'h18);
		check(32'(done4), 32'h3);
		apb(1'b0, 12'h0b8, 32'h0);
		check(rdata, 32'h0);
		apb(1'b0, 12'h0b0, 32'h0);
		check(rdata, 32'h108);
		apb(1'b0, 12'h00c, 32'h0);
		check({rdata[31:1], threshold_irq}, 32'h0020_0000);
		final_report();
	end
endmodule : input_port_dma_bench

/* verif/memory_partner.sv */
`timescale 1ns/1ps
module memory_partner (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        dma_req,
	input  wire logic [31:0] dma_addr,
	input  wire logic [31:0] dma_data,
	input  wire logic [3:0]  stall,
	output logic             dma_grant
);
	logic [31:0] addr_log[$];
	logic [31:0] data_log[$];
	logic [3:0]  waited;

	// slow memory: a write lands only after stall cycles of pending request
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			dma_grant <= 1'b0;
			waited    <= 4'h0;
		end
		else if (dma_grant)
		begin
			dma_grant <= 1'b0;
			waited    <= 4'h0;
		end
		else if (dma_req && waited >= stall)
		begin
			dma_grant <= 1'b1;
			addr_log.push_back(dma_addr);
			data_log.push_back(dma_data);
		end
		else if (dma_req)
			waited <= waited + 4'h1;
	end
endmodule : memory_partner
